//--- ctc_conv.sv
`timescale 1ns/1ps

// ****************************************************************
// Shared constants of the charge-termination block.
// ****************************************************************
package ctc_pkg;
    // System clock rate in hertz.
    localparam int unsigned CLK_HZ          = 32'h0BEB_C200;
    // Converter step in microvolts; one code step of a sample.
    localparam int unsigned ADC_STEP_UV     = 32'h0000_09C4;
    // Conversion window in milliseconds, and its length in clock cycles.
    localparam int unsigned CONV_TIME_MS    = 32'h0000_0005;
    localparam int unsigned CONV_CYCLES     = CLK_HZ / 32'h0000_03E8 * CONV_TIME_MS;
    // Millisecond timebase used to measure the sampling interval.
    localparam int unsigned TICK_TIME_MS    = 32'h0000_0001;
    localparam int unsigned TICK_CYCLES     = CLK_HZ / 32'h0000_03E8 * TICK_TIME_MS;
    // Shortest and longest sampling interval in seconds.
    localparam int unsigned INTERVAL_MIN_S  = 32'h0000_0015;
    localparam int unsigned INTERVAL_MAX_S  = 32'h0000_00A8;
    // Shortest interval in ticks; each select step doubles it.
    localparam int unsigned INTERVAL_MIN_MS = INTERVAL_MIN_S * 32'h0000_03E8;
    // Width of the interval counter in ticks.
    localparam int unsigned INTERVAL_W      = 32'h0000_0012;
    // Default width of a converter sample.
    localparam int unsigned ADC_W_DEF       = 32'h0000_000C;

    // Charge states, one-hot.
    typedef enum logic [1:0] {
        CHG_TRICKLE = 2'h1,
        CHG_FAST    = 2'h2
    } ctc_chg_t;

    // Sampling sequence states, one-hot.
    typedef enum logic [3:0] {
        SEQ_WAIT1 = 4'h1,
        SEQ_CONV1 = 4'h2,
        SEQ_WAIT2 = 4'h4,
        SEQ_CONV2 = 4'h8
    } ctc_seq_t;
endpackage

// ****************************************************************
// Conversion window: holds a sample once its window has elapsed.
// ****************************************************************
module ctc_conv #(
    parameter int unsigned ADC_W       = ctc_pkg::ADC_W_DEF,
    parameter int unsigned CONV_CYCLES = ctc_pkg::CONV_CYCLES
) (
    // Clock and synchronised reset.
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // Request and converter input.
    input  wire logic             start_i,
    input  wire logic [ADC_W-1:0] code_i,
    // Result.
    output logic                  busy_o,
    output logic                  done_o,
    output logic      [ADC_W-1:0] result_o
);
    logic [ADC_W-1:0] code_meta_ff;
    logic [ADC_W-1:0] code_sync_ff;
    logic [19:0]      win_cnt_ff;
    logic             busy_ff;
    logic             done_ff;
    logic [ADC_W-1:0] result_ff;

    // The converter code comes from outside this clock domain.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            code_meta_ff <= '0;
            code_sync_ff <= '0;
        end else begin
            code_meta_ff <= code_i;
            code_sync_ff <= code_meta_ff;
        end
    end

    // A window of fixed length, then the quantised code is held.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_ff    <= 1'b0;
            done_ff    <= 1'b0;
            win_cnt_ff <= '0;
            result_ff  <= '0;
        end else begin
            done_ff <= 1'b0;
            if (!busy_ff && start_i) begin
                busy_ff    <= 1'b1;
                win_cnt_ff <= 20'(CONV_CYCLES - 1);
            end else if (busy_ff) begin
                if (win_cnt_ff == '0) begin
                    busy_ff   <= 1'b0;
                    done_ff   <= 1'b1;
                    result_ff <= code_sync_ff;
                end else begin
                    win_cnt_ff <= win_cnt_ff - 20'h0_0001;
                end
            end
        end
    end

    assign busy_o   = busy_ff;
    assign done_o   = done_ff;
    assign result_o = result_ff;
endmodule

//--- ctc_charge_term.sv
`timescale 1ns/1ps

// What this block does
// - Samples quantised at 2.5mV steps for comparisons.
// - First sample after one interval from reset.
// - Each sample takes 5ms, then held.
// - Second sample after another interval, then compare.
// - No termination: repeat two-interval, two-sample cycle.
// - Zero-slope variant: equal samples end fast.
// - Negative-slope variant: drop of cells steps ends fast.
// - Hot ends fast; no resume on cooling.
// - Cold at start withholds fast until warm.
// - No battery: voltage limit times cells, no current.
// - Two states; timeout or slope forces trickle.
// - After full charge stay trickle until the battery is reinserted.

// ****************************************************************
// Charge-termination controller top.
// ****************************************************************
module ctc_charge_term #(
    parameter int unsigned ADC_W       = ctc_pkg::ADC_W_DEF,
    parameter int unsigned CONV_CYCLES = ctc_pkg::CONV_CYCLES,
    parameter int unsigned TICK_CYCLES = ctc_pkg::TICK_CYCLES
) (
    // Clock and reset.
    input  wire logic             clk_sys_i,
    input  wire logic             reset_n_i,
    // Battery voltage converter code, one step per 2.5mV.
    input  wire logic [ADC_W-1:0] batt_code_i,
    // Pack and temperature comparators.
    input  wire logic             batt_present_i,
    input  wire logic             hot_above_i,
    input  wire logic             cold_above_i,
    input  wire logic             timeout_i,
    // Configuration pins.
    input  wire logic             slope_negative_i,
    input  wire logic [1:0]       interval_sel_i,
    input  wire logic [1:0]       cell_count_select_a_i,
    input  wire logic [1:0]       cell_count_select_b_i,
    // Charge control.
    output logic                  fast_charge_o,
    output logic                  current_reg_en_o,
    output logic                  voltage_limit_en_o,
    output logic      [4:0]       limit_cells_o,
    // Sampling status.
    output logic                  sample_valid_o,
    output logic      [ADC_W-1:0] sample_code_o,
    output logic                  slope_term_o
);
    // Parameters the counters cannot serve are refused.
    if (ADC_W < 6 || ADC_W > 16) begin : g_bad_adc_w
        $error("ADC_W must be within 6 to 16");
    end
    if (CONV_CYCLES < 1 || CONV_CYCLES > 1048576) begin : g_bad_conv
        $error("CONV_CYCLES must be within 1 to 2**20");
    end
    if (TICK_CYCLES < 1 || TICK_CYCLES > 1048576) begin : g_bad_tick
        $error("TICK_CYCLES must be within 1 to 2**20");
    end

    localparam int unsigned NSYNC = 11;

    logic [1:0]                rst_sync_ff;
    logic                      rst_n;
    logic [NSYNC-1:0]          pin_async;
    logic [NSYNC-1:0]          pin_meta_ff;
    logic [NSYNC-1:0]          pin_sync_ff;
    logic                      batt_s;
    logic                      hot_s;
    logic                      cold_s;
    logic                      tmo_s;
    logic                      neg_s;
    logic [5:0]                cfg_s;
    logic                      batt_prev_ff;
    logic [19:0]               tick_cnt_ff;
    logic                      tick_ff;
    logic [ctc_pkg::INTERVAL_W-1:0] ival_cnt_ff;
    logic [ctc_pkg::INTERVAL_W-1:0] ival_len;
    ctc_pkg::ctc_seq_t         seq_ff;
    logic                      conv_start;
    logic                      conv_done;
    logic [ADC_W-1:0]          conv_result;
    logic [ADC_W-1:0]          first_ff;
    logic [ADC_W:0]            drop;
    logic [4:0]                cells;
    logic                      slope_hit;
    logic                      slope_term_ff;
    logic                      sample_valid_ff;
    logic [ADC_W-1:0]          sample_code_ff;
    logic                      hot_lock_ff;
    logic                      arm_ff;
    ctc_pkg::ctc_chg_t         chg_ff;
    ctc_pkg::ctc_chg_t         nxt_chg;

    // ************************************************************
    // Reset release and pin synchronisers.
    // ************************************************************

    // Reset asserts at once and releases through two flip-flops.
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // Every pin passes two flip-flops before use.
    assign pin_async = {cell_count_select_b_i, cell_count_select_a_i, interval_sel_i,
                        slope_negative_i, timeout_i, cold_above_i, hot_above_i, batt_present_i};

    for (genvar i = 0; i < NSYNC; i++) begin : g_sync
        always_ff @(posedge clk_sys_i or negedge rst_n) begin
            if (!rst_n) begin
                pin_meta_ff[i] <= 1'b0;
                pin_sync_ff[i] <= 1'b0;
            end else begin
                pin_meta_ff[i] <= pin_async[i];
                pin_sync_ff[i] <= pin_meta_ff[i];
            end
        end
    end

    assign batt_s = pin_sync_ff[0];
    assign hot_s  = pin_sync_ff[1];
    assign cold_s = pin_sync_ff[2];
    assign tmo_s  = pin_sync_ff[3];
    assign neg_s  = pin_sync_ff[4];
    assign cfg_s  = pin_sync_ff[10:5];

    // Cell count 1..16 from the two select pin pairs.
    assign cells = {1'b0, cfg_s[3:2], cfg_s[5:4]} + 5'h01;

    // ************************************************************
    // Millisecond timebase and sampling interval.
    // ************************************************************

    // Divider making a one-cycle enable every millisecond.
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_ff <= '0;
            tick_ff     <= 1'b0;
        end else if (tick_cnt_ff == 20'(TICK_CYCLES - 1)) begin
            tick_cnt_ff <= '0;
            tick_ff     <= 1'b1;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 20'h0_0001;
            tick_ff     <= 1'b0;
        end
    end

    // Interval doubles per select step, from shortest to longest.
    assign ival_len = ctc_pkg::INTERVAL_W'(ctc_pkg::INTERVAL_MIN_MS) << cfg_s[1:0];

    // ************************************************************
    // Sampling sequence: interval, sample, interval, sample.
    // ************************************************************

    // Interval counter runs only in the waiting states.
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            ival_cnt_ff <= '0;
        end else if (seq_ff == ctc_pkg::SEQ_CONV1 || seq_ff == ctc_pkg::SEQ_CONV2) begin
            ival_cnt_ff <= '0;
        end else if (tick_ff) begin
            ival_cnt_ff <= ival_cnt_ff + ctc_pkg::INTERVAL_W'(1);
        end
    end

    // A window starts when an interval has fully elapsed.
    assign conv_start = tick_ff && (ival_cnt_ff + ctc_pkg::INTERVAL_W'(1) >= ival_len) &&
                        (seq_ff == ctc_pkg::SEQ_WAIT1 || seq_ff == ctc_pkg::SEQ_WAIT2);

    // Sequence steps; the cycle repeats whether or not termination occurs.
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            seq_ff <= ctc_pkg::SEQ_WAIT1;
        end else begin
            case (seq_ff)
                ctc_pkg::SEQ_WAIT1: begin
                    if (conv_start) begin
                        seq_ff <= ctc_pkg::SEQ_CONV1;
                    end
                end
                ctc_pkg::SEQ_CONV1: begin
                    if (conv_done) begin
                        seq_ff <= ctc_pkg::SEQ_WAIT2;
                    end
                end
                ctc_pkg::SEQ_WAIT2: begin
                    if (conv_start) begin
                        seq_ff <= ctc_pkg::SEQ_CONV2;
                    end
                end
                ctc_pkg::SEQ_CONV2: begin
                    if (conv_done) begin
                        seq_ff <= ctc_pkg::SEQ_WAIT1;
                    end
                end
                default: begin
                    seq_ff <= ctc_pkg::SEQ_WAIT1;
                end
            endcase
        end
    end

    // Conversion window with the held result.
    ctc_conv #(
        .ADC_W       (ADC_W),
        .CONV_CYCLES (CONV_CYCLES)
    ) u_conv (
        .clk_i    (clk_sys_i),
        .rst_n_i  (rst_n),
        .start_i  (conv_start),
        .code_i   (batt_code_i),
        .busy_o   (),
        .done_o   (conv_done),
        .result_o (conv_result)
    );

    // ************************************************************
    // Slope decision.
    // ************************************************************

    // The first sample of a cycle is kept for the comparison.
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            first_ff <= '0;
        end else if (conv_done && seq_ff == ctc_pkg::SEQ_CONV1) begin
            first_ff <= conv_result;
        end
    end

    // Drop from first to second sample, in converter steps.
    assign drop = {1'b0, first_ff} - {1'b0, conv_result};

    // Zero slope: equal codes; negative slope: drop of one step per cell.
    always_comb begin
        slope_hit = 1'b0;
        if (conv_done && seq_ff == ctc_pkg::SEQ_CONV2) begin
            if (neg_s) begin
                slope_hit = !drop[ADC_W] && (drop >= (ADC_W + 1)'(cells));
            end else begin
                slope_hit = (conv_result == first_ff);
            end
        end
    end

    // Reported samples and the termination pulse.
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            sample_valid_ff <= 1'b0;
            sample_code_ff  <= '0;
            slope_term_ff   <= 1'b0;
        end else begin
            sample_valid_ff <= conv_done;
            slope_term_ff   <= slope_hit && (chg_ff == ctc_pkg::CHG_FAST);
            if (conv_done) begin
                sample_code_ff <= conv_result;
            end
        end
    end

    // ************************************************************
    // Charge state.
    // ************************************************************

    // Hot at any time locks out fast charge until the next reset.
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            hot_lock_ff <= 1'b0;
        end else if (hot_s) begin
            hot_lock_ff <= 1'b1;
        end
    end

    // One fast-charge attempt per power-up or per battery insertion.
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            arm_ff       <= 1'b1;
            batt_prev_ff <= 1'b0;
        end else begin
            batt_prev_ff <= batt_s;
            if (chg_ff == ctc_pkg::CHG_FAST) begin
                arm_ff <= 1'b0;
            end else if (batt_s && !batt_prev_ff && chg_ff == ctc_pkg::CHG_TRICKLE) begin
                arm_ff <= 1'b1;
            end
        end
    end

    // Next charge state; termination overrides every entry condition.
    always_comb begin
        nxt_chg = chg_ff;
        case (chg_ff)
            ctc_pkg::CHG_TRICKLE: begin
                if (arm_ff && batt_s && !cold_s && !hot_s && !hot_lock_ff &&
                    !tmo_s && !slope_hit) begin
                    nxt_chg = ctc_pkg::CHG_FAST;
                end
            end
            ctc_pkg::CHG_FAST: begin
                if (tmo_s || slope_hit || hot_s) begin
                    nxt_chg = ctc_pkg::CHG_TRICKLE;
                end
            end
            default: begin
                nxt_chg = ctc_pkg::CHG_TRICKLE;
            end
        endcase
    end

    // Charge state register, trickle from reset.
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            chg_ff <= ctc_pkg::CHG_TRICKLE;
        end else begin
            chg_ff <= nxt_chg;
        end
    end

    // Regulation mode: no battery means voltage limit only.
    logic       cur_en_ff;
    logic       vlim_en_ff;
    logic [4:0] lim_cells_ff;

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            cur_en_ff    <= 1'b0;
            vlim_en_ff   <= 1'b1;
            lim_cells_ff <= 5'h01;
        end else begin
            cur_en_ff    <= batt_s;
            vlim_en_ff   <= !batt_s;
            lim_cells_ff <= cells;
        end
    end

    assign fast_charge_o      = (chg_ff == ctc_pkg::CHG_FAST);
    assign current_reg_en_o   = cur_en_ff;
    assign voltage_limit_en_o = vlim_en_ff;
    assign limit_cells_o      = lim_cells_ff;
    assign sample_valid_o     = sample_valid_ff;
    assign sample_code_o      = sample_code_ff;
    assign slope_term_o       = slope_term_ff;
endmodule

//--- ctc_charge_term_properties.sv
`timescale 1ns/1ps

// ****************************************************************
// Port checks of the charge-termination top.
// ****************************************************************
module ctc_charge_term_properties (
    input  wire logic       clk_sys_i,
    input  wire logic       reset_n_i,
    input  wire logic       batt_present_i,
    input  wire logic       hot_above_i,
    input  wire logic       cold_above_i,
    input  wire logic       timeout_i,
    input  wire logic [1:0] cell_count_select_a_i,
    input  wire logic [1:0] cell_count_select_b_i,
    input  wire logic       fast_charge_o,
    input  wire logic       current_reg_en_o,
    input  wire logic       voltage_limit_en_o,
    input  wire logic [4:0] limit_cells_o,
    input  wire logic       sample_valid_o,
    input  wire logic       slope_term_o
);
    logic [3:0] up_cnt_ff;
    logic       hot_seen_ff;
    logic       up_ok;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    // Counts cycles after release, so checks skip the synchroniser lag.
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) up_cnt_ff <= 4'h0;
        else if (up_cnt_ff != 4'hF) up_cnt_ff <= up_cnt_ff + 4'h1;
    end

    // Remembers any hot reading since the last reset.
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) hot_seen_ff <= 1'b0;
        else if (hot_above_i) hot_seen_ff <= 1'b1;
    end

    // Startup lag of the pin synchronisers is over.
    assign up_ok = (up_cnt_ff == 4'hF);

    AST_SLOPE_TERM_TRICKLE: assert property (slope_term_o |-> !fast_charge_o)
        else $error("slope end seen while still in fast charge");
    AST_SLOPE_TERM_PULSE: assert property (slope_term_o |=> !slope_term_o)
        else $error("slope end pulse longer than one cycle");
    AST_SAMPLE_PULSE: assert property (sample_valid_o |=> !sample_valid_o)
        else $error("sample pulse longer than one cycle");
    AST_SLOPE_AFTER_SAMPLE: assert property (slope_term_o |->
        sample_valid_o || $past(sample_valid_o) || $past(sample_valid_o, 2))
        else $error("slope end without a completed sample");
    AST_HOT_ENDS_FAST: assert property (up_ok && hot_above_i |-> ##[1:5] !fast_charge_o)
        else $error("fast charge kept while hot");
    AST_HOT_NO_RESUME: assert property ($rose(fast_charge_o) |-> !$past(hot_seen_ff, 4))
        else $error("fast charge resumed after a hot reading");
    AST_COLD_WITHHOLD: assert property ((up_ok && cold_above_i)[*5] |-> !$rose(fast_charge_o))
        else $error("fast charge started while cold");
    AST_TIMEOUT_TRICKLE: assert property (up_ok && timeout_i |-> ##[1:5] !fast_charge_o)
        else $error("fast charge kept after timeout");
    AST_NO_BATT_LIMIT: assert property ((up_ok && $stable(batt_present_i))[*5] |->
        voltage_limit_en_o == !batt_present_i && current_reg_en_o == batt_present_i)
        else $error("regulation mode does not follow battery presence");
    AST_CELL_COUNT: assert property ((up_ok && $stable(cell_count_select_a_i) &&
        $stable(cell_count_select_b_i))[*3] |->
        limit_cells_o == {1'b0, cell_count_select_a_i, cell_count_select_b_i} + 5'h01)
        else $error("cell count does not follow the select pins");

    COV_SAMPLE: cover property (sample_valid_o);
    COV_SLOPE_END: cover property (slope_term_o);
    COV_FAST_ENTRY: cover property ($rose(fast_charge_o));
endmodule

bind ctc_charge_term ctc_charge_term_properties i_props (.clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i), .batt_present_i(batt_present_i), .hot_above_i(hot_above_i),
    .cold_above_i(cold_above_i), .timeout_i(timeout_i),
    .cell_count_select_a_i(cell_count_select_a_i),
    .cell_count_select_b_i(cell_count_select_b_i), .fast_charge_o(fast_charge_o),
    .current_reg_en_o(current_reg_en_o), .voltage_limit_en_o(voltage_limit_en_o),
    .limit_cells_o(limit_cells_o), .sample_valid_o(sample_valid_o),
    .slope_term_o(slope_term_o));

//--- ctc_pack_model.sv
`timescale 1ns/1ps

// ****************************************************************
// Battery pack model: voltage code seen by the converter.
// ****************************************************************
module ctc_pack_model (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        sample_valid_i,
    input  wire logic [11:0] base_i,
    input  wire logic [11:0] drop_i,
    output logic      [11:0] batt_code_o
);
    logic sampled_ff;

    // The pack sags by the drop once the first sample is held.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) sampled_ff <= 1'b0;
        else if (sample_valid_i) sampled_ff <= 1'b1;
    end

    // Voltage code presented to the converter.
    assign batt_code_o = sampled_ff ? base_i - drop_i : base_i;
endmodule

//--- tb.sv
`timescale 1ns/1ps

// ****************************************************************
// Self-checking bench of the charge-termination top.
// ****************************************************************
module tb;
    localparam int TICK = 1;
    localparam int CONV = 4;
    logic        clk_sys_i      = 1'b0;
    logic        reset_n_i      = 1'b0;
    logic        batt_present_i = 1'b1;
    logic        hot_above_i    = 1'b0;
    logic        cold_above_i   = 1'b1;
    logic        timeout_i      = 1'b0;
    logic        term_seen      = 1'b0;
    logic [1:0]  sel_a          = 2'h0;
    logic [1:0]  sel_b          = 2'h0;
    logic [11:0] base           = 12'h0000;
    logic [11:0] drop           = 12'h0000;
    logic [11:0] code_neg;
    logic [11:0] code_zero;
    logic [11:0] sample_code;
    logic [4:0]  limit_cells;
    logic        fast_neg;
    logic        fast_zero;
    logic        term_neg;
    logic        cur_en;
    logic        vlim_en;
    logic        valid_neg;
    logic        valid_zero;
    int          err_total      = 0;
    int          checks_done    = 0;
    int          n              = 0;

    // Free-running 200 MHz system clock.
    always #2.5 clk_sys_i = ~clk_sys_i;

    // Latches any slope end pulse of the negative-slope unit.
    always @(posedge clk_sys_i) begin
        if (term_neg === 1'b1) term_seen <= 1'b1;
    end

    // Battery packs, both sagging by the cell count after their first sample.
    ctc_pack_model i_pack_neg (.clk_i(clk_sys_i), .rst_n_i(reset_n_i), .sample_valid_i(valid_neg),
        .base_i(base), .drop_i(drop), .batt_code_o(code_neg));
    ctc_pack_model i_pack_zero (.clk_i(clk_sys_i), .rst_n_i(reset_n_i),
        .sample_valid_i(valid_zero), .base_i(base), .drop_i(drop), .batt_code_o(code_zero));

    // Negative-slope unit under test.
    ctc_charge_term #(.CONV_CYCLES(CONV), .TICK_CYCLES(TICK)) i_dut (.clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i), .batt_code_i(code_neg), .batt_present_i(batt_present_i),
        .hot_above_i(hot_above_i), .cold_above_i(cold_above_i), .timeout_i(timeout_i),
        .slope_negative_i(1'b1), .interval_sel_i(2'h0), .cell_count_select_a_i(sel_a),
        .cell_count_select_b_i(sel_b), .fast_charge_o(fast_neg), .current_reg_en_o(cur_en),
        .voltage_limit_en_o(vlim_en), .limit_cells_o(limit_cells), .sample_valid_o(valid_neg),
        .sample_code_o(sample_code), .slope_term_o(term_neg));

    // Zero-slope unit running beside it.
    ctc_charge_term #(.CONV_CYCLES(CONV), .TICK_CYCLES(TICK)) i_dut_zero (.clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i), .batt_code_i(code_zero), .batt_present_i(batt_present_i),
        .hot_above_i(hot_above_i), .cold_above_i(cold_above_i), .timeout_i(timeout_i),
        .slope_negative_i(1'b0), .interval_sel_i(2'h0), .cell_count_select_a_i(sel_a),
        .cell_count_select_b_i(sel_b), .fast_charge_o(fast_zero), .current_reg_en_o(),
        .voltage_limit_en_o(), .limit_cells_o(), .sample_valid_o(valid_zero),
        .sample_code_o(), .slope_term_o());

    // Expected cell count from the two select pairs.
    function automatic logic [4:0] cells_of(input logic [1:0] a, input logic [1:0] b);
        return {1'b0, a, b} + 5'h01;
    endfunction

    // Expected sampling interval in clock cycles.
    function automatic int span(input int sel);
        return (TICK * ctc_pkg::INTERVAL_MIN_MS) << sel;
    endfunction

    // Reports and counts a mismatch.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Selects a watched output by number.
    function automatic logic pick(input int w);
        return (w == 0) ? fast_neg : valid_neg;
    endfunction

    // Waits a bounded number of cycles for an output level.
    task automatic wait_for(input int w, input logic val, input int lim);
        n = 0;
        do begin
            @(posedge clk_sys_i);
            #1;
            n++;
            if (n > lim) begin
                check(16'(pick(w)), 16'(val));
                print_verdict();
            end
        end while (pick(w) !== val);
        @(posedge clk_sys_i);
    endtask

    // Holds reset for ten cycles, then releases it.
    task automatic do_reset();
        reset_n_i <= 1'b0;
        repeat (10) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
    endtask

    // Main sequence: state rules first, then two full sampling cycles.
    initial begin
        void'($urandom(37));
        @(posedge clk_sys_i);
        sel_a <= 2'($urandom());
        sel_b <= 2'($urandom());
        base  <= 12'($urandom_range(4000, 64));
        @(posedge clk_sys_i);
        drop <= 12'(cells_of(sel_a, sel_b));
        do_reset();
        repeat (20) @(posedge clk_sys_i);
        check(16'(fast_neg), 16'h0000);
        check(16'(limit_cells), 16'(cells_of(sel_a, sel_b)));
        check(16'(vlim_en), 16'h0000);
        cold_above_i <= 1'b0;
        wait_for(0, 1'b1, 20);
        timeout_i <= 1'b1;
        @(posedge clk_sys_i);
        timeout_i <= 1'b0;
        wait_for(0, 1'b0, 20);
        batt_present_i <= 1'b0;
        repeat (20) @(posedge clk_sys_i);
        check(16'(fast_neg), 16'h0000);
        check(16'(vlim_en), 16'h0001);
        check(16'(cur_en), 16'h0000);
        batt_present_i <= 1'b1;
        wait_for(0, 1'b1, 20);
        hot_above_i <= 1'b1;
        wait_for(0, 1'b0, 20);
        hot_above_i <= 1'b0;
        batt_present_i <= 1'b0;
        repeat (10) @(posedge clk_sys_i);
        batt_present_i <= 1'b1;
        repeat (20) @(posedge clk_sys_i);
        check(16'(fast_neg), 16'h0000);
        do_reset();
        wait_for(1, 1'b1, 50000);
        check(16'(n >= span(0) && n <= span(0) + CONV + 12), 16'h0001);
        check(16'(sample_code), 16'(base));
        check(16'({fast_neg, fast_zero}), 16'h0003);
        wait_for(1, 1'b1, 50000);
        check(16'(n >= span(0) && n <= span(0) + CONV + 8), 16'h0001);
        check(16'(sample_code), 16'(base - drop));
        repeat (4) @(posedge clk_sys_i);
        check(16'(fast_neg), 16'h0000);
        check(16'(fast_zero), 16'h0001);
        check(16'(term_seen), 16'h0001);
        wait_for(1, 1'b1, 50000);
        check(16'(n >= span(0) - 8 && n <= span(0) + CONV + 8), 16'h0001);
        wait_for(1, 1'b1, 50000);
        repeat (4) @(posedge clk_sys_i);
        check(16'(fast_zero), 16'h0000);
        print_verdict();
    end
endmodule
